// File: shared/omx_params.svh
/*
 Constants of the OR, copy and pointer-load execution block:
 opcodes, access bank split, flag positions, register offsets,
 reset values.
 Assumes it is included by its bare name before any use.
*/
`ifndef OMX_PARAMS_SVH
`define OMX_PARAMS_SVH

// Opcode fields
`define OMX_OPC_OR_LIT       8'h09
`define OMX_OPC_OR_REG       6'h04
`define OMX_OPC_COPY         6'h14
`define OMX_OPC_PTR_HI       10'h3B8
`define OMX_OPC_PTR_LO       8'hF0

// Access bank mapping
`define OMX_ACCESS_SPLIT     8'h80
`define OMX_ACCESS_LOW_BANK  4'h0
`define OMX_ACCESS_HIGH_BANK 4'hF

// Pointer set
`define OMX_PTR_LAST         2'h2
`define OMX_PTR_SPAN         4'h6

// Status bits and result sign
`define OMX_NEG_BIT          4
`define OMX_ZERO_BIT         2
`define OMX_RESULT_SIGN      7

// Register offsets on the software port
`define OMX_OFF_ACC          4'h0
`define OMX_OFF_STATUS       4'h1
`define OMX_OFF_BANK         4'h2
`define OMX_OFF_PTR_BASE     4'h3
`define OMX_OFF_PHASE        4'h9

// Reset values
`define OMX_RST_BYTE         8'h00
`define OMX_RST_BANK         4'h0

`endif

// File: shared/omx_pkg.sv
/*
 Types of the OR, copy and pointer-load execution block.
 Assumes nothing of its surroundings.
*/
package omx_pkg;

   typedef enum logic [2:0] {
      OMX_IDLE = 3'h0,
      OMX_Q1   = 3'h1,
      OMX_Q2   = 3'h3,
      OMX_Q3   = 3'h2,
      OMX_Q4   = 3'h6
   } omx_phase_t;

   typedef enum logic [2:0] {
      OMX_OP_NONE   = 3'h0,
      OMX_OP_OR_LIT = 3'h1,
      OMX_OP_OR_REG = 3'h2,
      OMX_OP_COPY   = 3'h3,
      OMX_OP_PTR_HI = 3'h4,
      OMX_OP_PTR_LO = 3'h5
   } omx_op_t;

   typedef struct packed {
      omx_op_t     op;
      logic        to_reg;
      logic        use_bank;
      logic [1:0]  ptr_idx;
      logic [7:0]  lit;
      logic [11:0] addr;
   } omx_dec_t;

   typedef struct packed {
      logic [11:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } omx_mem_req_t;

endpackage

// File: rtl/omx_decode.sv
/*
 Combinational decoder of one instruction word: operation, destination
 and access selects, pointer index, literal and mapped data address.
 Assumes the bank select value is stable while the word is presented.
*/
`timescale 1ns/1ns
`include "omx_params.svh"

module omx_decode (
   input  wire logic [15:0]     word,
   input  wire logic [3:0]      bank,
   output omx_pkg::omx_dec_t    dec
);

   always_comb begin
      dec          = '0;
      dec.op       = omx_pkg::OMX_OP_NONE;
      dec.lit      = word[7:0];
      dec.to_reg   = word[9];
      dec.use_bank = word[8];
      dec.ptr_idx  = word[5:4];
      if (word[8]) begin
         dec.addr = {bank, word[7:0]};
      end else if (word[7:0] < `OMX_ACCESS_SPLIT) begin
         dec.addr = {`OMX_ACCESS_LOW_BANK, word[7:0]};
      end else begin
         dec.addr = {`OMX_ACCESS_HIGH_BANK, word[7:0]};
      end
      if (word[15:8] == `OMX_OPC_OR_LIT) begin
         dec.op = omx_pkg::OMX_OP_OR_LIT;
      end else if (word[15:10] == `OMX_OPC_OR_REG) begin
         dec.op = omx_pkg::OMX_OP_OR_REG;
      end else if (word[15:10] == `OMX_OPC_COPY) begin
         dec.op = omx_pkg::OMX_OP_COPY;
      end else if (word[15:6] == `OMX_OPC_PTR_HI) begin
         dec.op  = omx_pkg::OMX_OP_PTR_HI;
         dec.lit = {4'h0, word[3:0]};
      end else if (word[15:8] == `OMX_OPC_PTR_LO) begin
         dec.op = omx_pkg::OMX_OP_PTR_LO;
      end
   end

endmodule

// File: rtl/omx_core.sv
/*
 Execution block for literal OR, register OR, copy with flags and the
 two-word pointer load, with a plain software register port.
 Assumes the fetch stage holds a word until taken, and data memory
 answers a read strobe with data in the following cycle, same clock.
*/
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`include "omx_params.svh"

// Function
// - Opcode 0x09 ORs the literal into the accumulator.
// - OR and copy set negative and zero only; pointer load no flags.
// - Destination bit 0 writes the accumulator; register unchanged.
// - Destination bit 1 writes the result back to the register.
// - Access bit 0 maps the address into the fixed access bank.
// - Access bit 1 takes upper address bits from bank select.
// - The register address field is eight bits, one 256-byte bank.
// - Copy passes the register unchanged to the chosen destination.
// - Register OR combines accumulator and register to the destination.
// - Pointer load is two words: index and high bits, then low byte.
// - Pointer high byte written in first cycle, low byte in second.
// - Two-bit index picks one of pointers 0 to 2.
module omx_core #(
   parameter int PTR_COUNT = 3
) (
   input  wire logic                 clock,
   input  wire logic                 resetn,
   input  wire logic [15:0]          instr_word,
   input  wire logic                 instr_valid,
   output logic                      instr_ready,
   output omx_pkg::omx_mem_req_t     mem_req,
   input  wire logic [7:0]           mem_rdata,
   input  wire logic [3:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic [7:0]                reg_rdata,
   output logic                      illegal_op
);

   omx_pkg::omx_phase_t    phase_reg;
   omx_pkg::omx_dec_t      dec;
   omx_pkg::omx_dec_t      dec_reg;
   omx_pkg::omx_mem_req_t  mem_req_reg;
   logic [7:0]             acc_reg;
   logic [7:0]             status_reg;
   logic [3:0]             bank_reg;
   logic [7:0]             ptr_hi_reg [PTR_COUNT];
   logic [7:0]             ptr_lo_reg [PTR_COUNT];
   logic                   pend_reg;
   logic [1:0]             pend_idx_reg;
   logic [7:0]             result_reg;
   logic [7:0]             result_next;
   logic [7:0]             operand;
   logic                   ready_reg;
   logic                   illegal_reg;
   logic [7:0]             rdata_reg;
   logic                   accept;
   logic                   good_word;
   logic                   exec_q4;
   logic [3:0]             ptr_sel;

   function automatic logic is_reg_op(input omx_pkg::omx_op_t op);
      return (op == omx_pkg::OMX_OP_OR_REG) || (op == omx_pkg::OMX_OP_COPY);
   endfunction

   function automatic logic sets_flags(input omx_pkg::omx_op_t op);
      return is_reg_op(op) || (op == omx_pkg::OMX_OP_OR_LIT);
   endfunction

   // Pointer slot of a software address: valid, index, low byte
   function automatic logic [3:0] ptr_slot(input logic [3:0] addr);
      logic [3:0] off;
      off = addr - `OMX_OFF_PTR_BASE;
      return {(addr >= `OMX_OFF_PTR_BASE) && (off < `OMX_PTR_SPAN),
              off[2:1], off[0]};
   endfunction

   omx_decode u_decode (
      .word (instr_word),
      .bank (bank_reg),
      .dec  (dec)
   );

   assign accept      = instr_valid && ready_reg;
   assign exec_q4     = (phase_reg == omx_pkg::OMX_Q4);
   assign instr_ready = ready_reg;
   assign mem_req     = mem_req_reg;
   assign reg_rdata   = rdata_reg;
   assign illegal_op  = illegal_reg;
   assign ptr_sel     = ptr_slot(reg_addr);

   // A second word is only legal after a first word
   always_comb begin
      if (pend_reg) begin
         good_word = (dec.op == omx_pkg::OMX_OP_PTR_LO);
      end else begin
         good_word = (dec.op != omx_pkg::OMX_OP_NONE) &&
                     (dec.op != omx_pkg::OMX_OP_PTR_LO) &&
                     !((dec.op == omx_pkg::OMX_OP_PTR_HI) &&
                       (dec.ptr_idx > `OMX_PTR_LAST));
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         phase_reg <= omx_pkg::OMX_IDLE;
      end else begin
         case (phase_reg)
            omx_pkg::OMX_IDLE: begin
               if (accept && good_word) begin
                  phase_reg <= omx_pkg::OMX_Q1;
               end
            end
            omx_pkg::OMX_Q1: phase_reg <= omx_pkg::OMX_Q2;
            omx_pkg::OMX_Q2: phase_reg <= omx_pkg::OMX_Q3;
            omx_pkg::OMX_Q3: phase_reg <= omx_pkg::OMX_Q4;
            default:         phase_reg <= omx_pkg::OMX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         ready_reg   <= 1'b1;
         illegal_reg <= 1'b0;
         dec_reg     <= '0;
      end else begin
         illegal_reg <= accept && !good_word;
         if (accept && good_word) begin
            ready_reg <= 1'b0;
            dec_reg   <= dec;
         end else if (exec_q4) begin
            ready_reg <= 1'b1;
         end
      end
   end

   // Pending second word of a pointer load
   always_ff @(posedge clock) begin
      if (!resetn) begin
         pend_reg     <= 1'b0;
         pend_idx_reg <= 2'h0;
      end else if (accept && !good_word && pend_reg) begin
         pend_reg <= 1'b0;
      end else if (exec_q4 && dec_reg.op == omx_pkg::OMX_OP_PTR_HI) begin
         pend_reg     <= 1'b1;
         pend_idx_reg <= dec_reg.ptr_idx;
      end else if (exec_q4 && dec_reg.op == omx_pkg::OMX_OP_PTR_LO) begin
         pend_reg <= 1'b0;
      end
   end

   always_comb begin
      operand = is_reg_op(dec_reg.op) ? mem_rdata : dec_reg.lit;
      if (dec_reg.op == omx_pkg::OMX_OP_COPY) begin
         result_next = operand;
      end else begin
         result_next = acc_reg | operand;
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         result_reg <= `OMX_RST_BYTE;
      end else if (phase_reg == omx_pkg::OMX_Q3) begin
         result_reg <= result_next;
      end
   end

   // Read in phase two, write back in phase four
   always_ff @(posedge clock) begin
      if (!resetn) begin
         mem_req_reg <= '0;
      end else begin
         mem_req_reg.rd <= 1'b0;
         mem_req_reg.wr <= 1'b0;
         if (phase_reg == omx_pkg::OMX_Q1 && is_reg_op(dec_reg.op)) begin
            mem_req_reg.rd   <= 1'b1;
            mem_req_reg.addr <= dec_reg.addr;
         end
         if (phase_reg == omx_pkg::OMX_Q3 && is_reg_op(dec_reg.op) &&
             dec_reg.to_reg) begin
            mem_req_reg.wr    <= 1'b1;
            mem_req_reg.wdata <= result_next;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         acc_reg <= `OMX_RST_BYTE;
      end else if (exec_q4 && (dec_reg.op == omx_pkg::OMX_OP_OR_LIT ||
                  (is_reg_op(dec_reg.op) && !dec_reg.to_reg))) begin
         acc_reg <= result_reg;
      end else if (reg_wr && reg_addr == `OMX_OFF_ACC) begin
         acc_reg <= reg_wdata;
      end
   end

   // Negative and zero only, from the result
   always_ff @(posedge clock) begin
      if (!resetn) begin
         status_reg <= `OMX_RST_BYTE;
      end else if (exec_q4 && sets_flags(dec_reg.op)) begin
         status_reg[`OMX_NEG_BIT]  <= result_reg[`OMX_RESULT_SIGN];
         status_reg[`OMX_ZERO_BIT] <= (result_reg == `OMX_RST_BYTE);
      end else if (reg_wr && reg_addr == `OMX_OFF_STATUS) begin
         status_reg[`OMX_NEG_BIT]  <= reg_wdata[`OMX_NEG_BIT];
         status_reg[`OMX_ZERO_BIT] <= reg_wdata[`OMX_ZERO_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         bank_reg <= `OMX_RST_BANK;
      end else if (reg_wr && reg_addr == `OMX_OFF_BANK) begin
         bank_reg <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         for (int i = 0; i < PTR_COUNT; i++) begin
            ptr_hi_reg[i] <= `OMX_RST_BYTE;
            ptr_lo_reg[i] <= `OMX_RST_BYTE;
         end
      end else begin
         for (int i = 0; i < PTR_COUNT; i++) begin
            // High byte in the first cycle
            if (exec_q4 && dec_reg.op == omx_pkg::OMX_OP_PTR_HI &&
                dec_reg.ptr_idx == 2'(i)) begin
               ptr_hi_reg[i] <= dec_reg.lit;
            end else if (reg_wr && ptr_slot(reg_addr) ==
                         {1'b1, 2'(i), 1'b0}) begin
               ptr_hi_reg[i] <= reg_wdata;
            end
            // Low byte in the second cycle
            if (exec_q4 && dec_reg.op == omx_pkg::OMX_OP_PTR_LO &&
                pend_idx_reg == 2'(i)) begin
               ptr_lo_reg[i] <= dec_reg.lit;
            end else if (reg_wr && ptr_slot(reg_addr) ==
                         {1'b1, 2'(i), 1'b1}) begin
               ptr_lo_reg[i] <= reg_wdata;
            end
         end
      end
   end

   // Software read data, one cycle after the strobe
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_reg <= `OMX_RST_BYTE;
      end else if (reg_rd) begin
         if (ptr_sel[3]) begin
            rdata_reg <= ptr_sel[0] ? ptr_lo_reg[ptr_sel[2:1]] :
                                      ptr_hi_reg[ptr_sel[2:1]];
         end else begin
            case (reg_addr)
               `OMX_OFF_ACC:    rdata_reg <= acc_reg;
               `OMX_OFF_STATUS: rdata_reg <= status_reg;
               `OMX_OFF_BANK:   rdata_reg <= {4'h0, bank_reg};
               `OMX_OFF_PHASE:  rdata_reg <= {4'h0, pend_reg, phase_reg};
               default:         rdata_reg <= `OMX_RST_BYTE;
            endcase
         end
      end else begin
         rdata_reg <= `OMX_RST_BYTE;
      end
   end

   phase_order_a: assert property (
      @(posedge clock) disable iff (!resetn)
      phase_reg == omx_pkg::OMX_Q1 |=> phase_reg == omx_pkg::OMX_Q2
      ##1 phase_reg == omx_pkg::OMX_Q3 ##1 phase_reg == omx_pkg::OMX_Q4
      ##1 phase_reg == omx_pkg::OMX_IDLE)
      else $error("Quarter phases out of order");

   or_literal_a: assert property (
      @(posedge clock) disable iff (!resetn)
      phase_reg == omx_pkg::OMX_Q3 && dec_reg.op == omx_pkg::OMX_OP_OR_LIT
      |=> result_reg == ($past(acc_reg) | $past(dec_reg.lit))
      ##1 acc_reg == $past(result_reg))
      else $error("Literal OR result wrong");

   flag_update_a: assert property (
      @(posedge clock) disable iff (!resetn)
      exec_q4 && sets_flags(dec_reg.op) |=>
      status_reg[`OMX_NEG_BIT] == $past(result_reg[`OMX_RESULT_SIGN]) &&
      status_reg[`OMX_ZERO_BIT] == ($past(result_reg) == `OMX_RST_BYTE))
      else $error("Negative or zero flag wrong");

   ptr_flags_a: assert property (
      @(posedge clock) disable iff (!resetn)
      exec_q4 && !sets_flags(dec_reg.op) &&
      !(reg_wr && reg_addr == `OMX_OFF_STATUS) |=> $stable(status_reg))
      else $error("Pointer load changed flags");

   dest_acc_a: assert property (
      @(posedge clock) disable iff (!resetn)
      phase_reg == omx_pkg::OMX_Q3 && is_reg_op(dec_reg.op) &&
      !dec_reg.to_reg |=> !mem_req_reg.wr ##1 !mem_req_reg.wr)
      else $error("Register written with accumulator destination");

   dest_reg_a: assert property (
      @(posedge clock) disable iff (!resetn)
      phase_reg == omx_pkg::OMX_Q3 && is_reg_op(dec_reg.op) &&
      dec_reg.to_reg |=> mem_req_reg.wr &&
      mem_req_reg.wdata == result_reg && $stable(acc_reg) ##1 !mem_req_reg.wr)
      else $error("Register write back missing");

   access_bank_a: assert property (
      @(posedge clock) disable iff (!resetn)
      accept && good_word && is_reg_op(dec.op) && !dec.use_bank |-> ##2
      mem_req_reg.rd && mem_req_reg.addr[11:8] ==
      ($past(instr_word[7], 2) ? `OMX_ACCESS_HIGH_BANK :
       `OMX_ACCESS_LOW_BANK))
      else $error("Access bank mapping wrong");

   banked_addr_a: assert property (
      @(posedge clock) disable iff (!resetn)
      accept && good_word && is_reg_op(dec.op) && dec.use_bank |-> ##2
      mem_req_reg.rd && mem_req_reg.addr ==
      {$past(bank_reg, 2), $past(instr_word[7:0], 2)})
      else $error("Banked address wrong");

   ptr_high_a: assert property (
      @(posedge clock) disable iff (!resetn)
      exec_q4 && dec_reg.op == omx_pkg::OMX_OP_PTR_HI |=>
      pend_reg && ptr_hi_reg[pend_idx_reg] == $past(dec_reg.lit))
      else $error("Pointer high byte not loaded");

   ptr_low_a: assert property (
      @(posedge clock) disable iff (!resetn)
      exec_q4 && dec_reg.op == omx_pkg::OMX_OP_PTR_LO |=>
      !pend_reg && ptr_lo_reg[$past(pend_idx_reg)] == $past(dec_reg.lit))
      else $error("Pointer low byte not loaded");

endmodule

// File: dv/omx_mem_model.sv
/*
 Behavioural banked data memory on the far side of the execution block.
 Assumes one shared clock and read or write strobes one cycle long.
*/
`timescale 1ns/1ns
module omx_mem_model (
   input  wire omx_pkg::omx_mem_req_t mem_req,
   input  wire logic                  clock,
   output logic [7:0]                 mem_rdata
);
   logic [7:0] mem [4096];

   initial begin
      for (int i = 0; i < 4096; i++) begin
         mem[i] = 8'(i * 7 + 3);
      end
      mem_rdata = 8'h5A;
   end

   always @(posedge clock) begin
      if (mem_req.wr === 1'b1) begin
         mem[mem_req.addr] <= mem_req.wdata;
      end
      if (mem_req.rd === 1'b1) begin
         mem_rdata <= mem[mem_req.addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

// File: dv/or_move_pointer_load_exec_tb.sv
/*
 Self-checking bench of the execution block against a register image model.
 Assumes the memory model file and the shared package are compiled first.
*/
`timescale 1ns/1ns
`include "omx_params.svh"
module or_move_pointer_load_exec_tb;
   logic                  clock;
   logic                  resetn;
   logic [15:0]           instr_word;
   logic                  instr_valid;
   logic                  instr_ready;
   omx_pkg::omx_mem_req_t mem_req;
   logic [7:0]            mem_rdata;
   logic [3:0]            reg_addr;
   logic [7:0]            reg_wdata;
   logic                  reg_wr;
   logic                  reg_rd;
   logic [7:0]            reg_rdata;
   logic                  illegal_op;
   int                    error_cnt;
   int                    tests_run;
   logic [7:0]            reg_m [16];
   logic [7:0]            mem_m [4096];
   logic [11:0]           rd_seen;

   omx_core #(.PTR_COUNT(3)) DUT (
      .clock(clock), .resetn(resetn), .instr_word(instr_word),
      .instr_valid(instr_valid), .instr_ready(instr_ready),
      .mem_req(mem_req), .mem_rdata(mem_rdata), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .illegal_op(illegal_op)
   );

   omx_mem_model u_mem (
      .mem_req(mem_req), .clock(clock), .mem_rdata(mem_rdata)
   );

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   always @(posedge clock) begin
      if (mem_req.rd === 1'b1) begin
         rd_seen <= mem_req.addr;
      end
   end

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      if (a < 4'h9) begin
         reg_m[a] = (a == 4'h2) ? {4'h0, d[3:0]} :
                    (a == 4'h1) ? (d & 8'h14) : d;
      end
   endtask

   task automatic check_regs();
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         reg_addr <= 4'(i);
         reg_rd <= 1'b1;
         @(posedge clock);
         reg_rd <= 1'b0;
         #1 check(12'(reg_rdata), 12'(reg_m[i]));
      end
   endtask

   task automatic issue(input logic [15:0] w, input logic bad);
      int n;
      @(posedge clock);
      instr_word <= w;
      instr_valid <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (instr_ready !== 1'b1 && n < 20);
      instr_valid <= 1'b0;
      instr_word <= ~w;
      #1 check(12'(illegal_op), 12'(bad));
      check(12'(n < 20), 12'h001);
      check(12'(instr_ready), 12'(bad));
      if (!bad) begin
         repeat (4) @(posedge clock);
         #1 check(12'(instr_ready), 12'h001);
      end
   endtask

   task automatic set_flags(input logic [7:0] r);
      reg_m[1] = 8'h00;
      reg_m[1][`OMX_NEG_BIT] = r[`OMX_RESULT_SIGN];
      reg_m[1][`OMX_ZERO_BIT] = (r == 8'h00);
   endtask

   task automatic lit_op(input logic [7:0] k);
      issue({`OMX_OPC_OR_LIT, k}, 1'b0);
      reg_m[0] = reg_m[0] | k;
      set_flags(reg_m[0]);
      check_regs();
   endtask

   task automatic reg_op(input logic [5:0] opc, input logic d,
                         input logic a, input logic [7:0] f);
      logic [11:0] ad;
      logic [7:0]  r;
      ad = a ? {reg_m[2][3:0], f} : {(f < `OMX_ACCESS_SPLIT) ?
           `OMX_ACCESS_LOW_BANK : `OMX_ACCESS_HIGH_BANK, f};
      r = (opc == `OMX_OPC_OR_REG) ? (reg_m[0] | mem_m[ad]) : mem_m[ad];
      issue({opc, d, a, f}, 1'b0);
      if (d) begin
         mem_m[ad] = r;
      end else begin
         reg_m[0] = r;
      end
      set_flags(r);
      check(rd_seen, ad);
      check(12'(u_mem.mem[ad]), 12'(mem_m[ad]));
      check_regs();
   endtask

   initial begin
      logic [31:0] rnd;
      logic [5:0]  opc;
      logic [7:0]  f;
      logic [11:0] k;
      resetn = 1'b0;
      instr_word = 16'h0000;
      instr_valid = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      error_cnt = 0;
      tests_run = 0;
      rd_seen = 12'h000;
      foreach (reg_m[i]) reg_m[i] = 8'h00;
      for (int i = 0; i < 4096; i++) mem_m[i] = 8'(i * 7 + 3);
      rnd = $urandom(31);
      repeat (16) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      check_regs();
      reg_write(4'hC, 8'h5A);
      reg_write(4'h1, 8'hFF);
      reg_write(4'h6, 8'hA5);
      check_regs();
      lit_op(8'h00);
      for (int i = 0; i < 4; i++) begin
         rnd = $urandom;
         reg_write(4'h0, rnd[7:0]);
         lit_op(rnd[15:8]);
      end
      for (int i = 0; i < 32; i++) begin
         rnd = $urandom;
         opc = i[0] ? `OMX_OPC_COPY : `OMX_OPC_OR_REG;
         f = (i < 8) ? 8'h7F : (i < 16) ? 8'h80 : rnd[7:0];
         reg_write(4'h0, rnd[15:8]);
         reg_write(4'h2, rnd[23:16]);
         reg_op(opc, i[1], i[2], f);
      end
      for (int i = 0; i < 3; i++) begin
         rnd = $urandom;
         k = rnd[11:0];
         issue({`OMX_OPC_PTR_HI, 2'(i), k[11:8]}, 1'b0);
         reg_m[3 + 2 * i] = {4'h0, k[11:8]};
         reg_m[9] = 8'h08;
         check_regs();
         issue({`OMX_OPC_PTR_LO, k[7:0]}, 1'b0);
         reg_m[4 + 2 * i] = k[7:0];
         reg_m[9] = 8'h00;
         check_regs();
      end
      issue({`OMX_OPC_PTR_HI, 2'b11, 4'h5}, 1'b1);
      issue({`OMX_OPC_PTR_LO, 8'h12}, 1'b1);
      issue({`OMX_OPC_PTR_HI, 2'b01, 4'h7}, 1'b0);
      reg_m[5] = 8'h07;
      issue({`OMX_OPC_OR_LIT, 8'hFF}, 1'b1);
      issue(16'hFFFF, 1'b1);
      check_regs();
      give_verdict();
   end

   initial begin
      repeat (60000) @(posedge clock);
      error_cnt++;
      $display("BAD t=%0t watchdog expired", $time);
      give_verdict();
   end
endmodule
